/* File: cbi_coproc_port.v */
`timescale 1ns/100ps
`default_nettype none
`include "cbi_map.vh"
// Notes on behaviour
// - selection uses only the seven top address bits plus the memory/io line.
// - the window spans every address matched by those seven bits.
// - operation comes from word address bits 15..2 and three low lane enables.
// - writes into the window execute; reads drive the data lines.
// - select output goes low three clocks after the address starts to target the device.
// - all timing runs on the double-rate clock shared with the host.
// - presence output is driven low while the device is installed.
module cbi_coproc_port (
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire [29:0] word_address_bits_in,
	input  wire [3:0]  byte_lane_enables_n_in,
	input  wire [31:0] data_lines_in,
	input  wire        address_strobe_n_in,
	input  wire        mem_io_in,
	input  wire        write_read_in,
	input  wire        ready_n_in,
	input  wire        three_cycle_bus_n_in,
	output reg  [31:0] data_lines_out,
	output reg         data_lines_oe_out,
	output reg         coproc_selected_n_out,
	output reg         ready_n_out,
	output reg         interrupt_request_out,
	output reg         device_present_n_out,
	output reg         op_valid_out,
	output reg  [16:0] op_code_out,
	output reg  [31:0] op_data_out
);

	localparam ST_IDLE = 2'b00;
	localparam ST_WAIT = 2'b01;
	localparam ST_DONE = 2'b10;

	// first and second stage of the pin synchronisers
	reg [29:0]            addr_s1;
	reg [29:0]            addr_s2;
	reg [3:0]             be_s1;
	reg [3:0]             be_s2;
	reg [31:0]            din_s1;
	reg [31:0]            din_s2;
	reg                   ads_s1;
	reg                   ads_s2;
	reg                   mem_s1;
	reg                   mem_s2;
	reg                   wr_s1;
	reg                   wr_s2;
	reg                   rdy_s1;
	reg                   rdy_s2;
	reg                   tcb_s1;
	reg                   tcb_s2;

	// cycle state
	reg [1:0]             state;
	reg [1:0]             next_state;
	reg [1:0]             lat;
	reg                   cyc_wr;
	reg [16:0]            cyc_code;
	reg [31:0]            regs [0:`CBI_NUM_REGS-1];

	wire                  hit;
	wire                  take;
	wire                  finish;
	wire                  finish_wr;
	wire                  finish_rd;
	wire [16:0]           code;
	wire [`CBI_IDX_W-1:0] idx;

	assign hit       = mem_s2 && (addr_s2[`CBI_SEL_HI:`CBI_SEL_LO] == `CBI_SEL_MATCH);
	assign code      = {addr_s2[`CBI_OP_HI:`CBI_OP_LO], be_s2[`CBI_OP_LANE_HI:`CBI_LANE_LO]};
	assign idx       = cyc_code[`CBI_IDX_W+`CBI_IDX_LO-1:`CBI_IDX_LO];
	assign take      = (state == ST_IDLE) && !ads_s2 && hit;
	assign finish    = (state == ST_WAIT) && (lat == `CBI_LAT_ZERO);
	assign finish_wr = finish && cyc_wr;
	assign finish_rd = finish && !cyc_wr;

	// pin inputs pass two flip-flops
	always @(posedge clk_in) begin
		addr_s1 <= word_address_bits_in;
		addr_s2 <= addr_s1;
	end

	always @(posedge clk_in) begin
		be_s1 <= byte_lane_enables_n_in;
		be_s2 <= be_s1;
	end

	always @(posedge clk_in) begin
		din_s1 <= data_lines_in;
		din_s2 <= din_s1;
	end

	always @(posedge clk_in) begin
		ads_s1 <= address_strobe_n_in;
		ads_s2 <= ads_s1;
	end

	always @(posedge clk_in) begin
		mem_s1 <= mem_io_in;
		mem_s2 <= mem_s1;
	end

	always @(posedge clk_in) begin
		wr_s1 <= write_read_in;
		wr_s2 <= wr_s1;
	end

	always @(posedge clk_in) begin
		rdy_s1 <= ready_n_in;
		rdy_s2 <= rdy_s1;
	end

	always @(posedge clk_in) begin
		tcb_s1 <= three_cycle_bus_n_in;
		tcb_s2 <= tcb_s1;
	end

	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: if (take) next_state = ST_WAIT;
			ST_WAIT: if (finish) next_state = ST_DONE;
			ST_DONE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// capture of the cycle and its wait count
	always @(posedge clk_in) begin
		if (rst_in) begin
			cyc_wr   <= 1'b0;
			cyc_code <= `CBI_CODE_ZERO;
			lat      <= `CBI_LAT_ZERO;
		end else if (take) begin
			cyc_wr   <= wr_s2;
			cyc_code <= code;
			// the three-cycle bus allows one less wait
			lat      <= tcb_s2 ? `CBI_EXEC_LAT : `CBI_LAT_SHORT;
		end else if (state == ST_WAIT && lat != `CBI_LAT_ZERO) begin
			lat <= lat - `CBI_LAT_STEP;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `CBI_NUM_REGS; g = g + 1) begin : g_regs
			always @(posedge clk_in) begin
				if (rst_in) begin
					regs[g] <= `CBI_WORD_ZERO;
				end else if (finish_wr && idx == g) begin
					regs[g] <= din_s2;
				end
			end
		end
	endgenerate

	always @(posedge clk_in) begin
		if (rst_in) begin
			device_present_n_out <= 1'b0;
		end else begin
			device_present_n_out <= 1'b0;
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			coproc_selected_n_out <= 1'b1;
		end else begin
			coproc_selected_n_out <= ~hit;
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			ready_n_out <= 1'b1;
		end else begin
			ready_n_out <= ~finish;
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			op_valid_out <= 1'b0;
			op_code_out  <= `CBI_CODE_ZERO;
			op_data_out  <= `CBI_WORD_ZERO;
		end else begin
			op_valid_out <= finish_wr;
			if (finish_wr) begin
				op_code_out <= cyc_code;
				op_data_out <= din_s2;
			end
		end
	end

	always @(posedge clk_in) begin
		if (rst_in) begin
			data_lines_out <= `CBI_WORD_ZERO;
		end else if (finish_rd) begin
			data_lines_out <= regs[idx];
		end
	end

	// drive stays on one more cycle while the host still holds its ready low
	always @(posedge clk_in) begin
		if (rst_in) begin
			data_lines_oe_out <= 1'b0;
		end else if (finish_rd) begin
			data_lines_oe_out <= 1'b1;
		end else if (state == ST_DONE && !cyc_wr && !rdy_s2) begin
			data_lines_oe_out <= 1'b1;
		end else begin
			data_lines_oe_out <= 1'b0;
		end
	end

	// interrupt flags a write whose three low lane enables are all inactive
	always @(posedge clk_in) begin
		if (rst_in) begin
			interrupt_request_out <= 1'b0;
		end else if (finish_wr
			&& cyc_code[`CBI_OP_LANE_HI:`CBI_LANE_LO] == `CBI_LANES_OFF) begin
			interrupt_request_out <= 1'b1;
		end else if (finish_rd) begin
			interrupt_request_out <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* File: cbi_map.vh */
`ifndef CBI_MAP_VH
`define CBI_MAP_VH
// window decode on the upper seven address bits
`define CBI_SEL_HI      29
`define CBI_SEL_LO      23
`define CBI_SEL_MATCH   7'h60
// operation field: word address bits 15..2
`define CBI_OP_HI       13
`define CBI_OP_LO       0
// instruction code layout: opcode 14 bits, lane enables 3 bits
`define CBI_CODE_W      17
`define CBI_NUM_REGS    8
`define CBI_IDX_W       3
`define CBI_DATA_W      32
`define CBI_LANE_W      4
`define CBI_EXEC_LAT    2'h2
`define CBI_LAT_SHORT   2'h1
`define CBI_LAT_STEP    2'h1
`define CBI_LAT_ZERO    2'h0
// lane enable field inside the instruction code
`define CBI_OP_LANE_HI  2
`define CBI_LANE_LO     0
`define CBI_LANES_OFF   3'h7
// register index position inside the instruction code
`define CBI_IDX_LO      3
`define CBI_WORD_ZERO   32'h0
`define CBI_CODE_ZERO   17'h0
`endif

/* File: cbi_port_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module cbi_port_asserts (
	input wire logic        clk_in, rst_in, address_strobe_n_in, mem_io_in, op_valid_out,
	input wire logic        coproc_selected_n_out, ready_n_out, device_present_n_out,
	input wire logic [29:0] word_address_bits_in
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	wire logic win = word_address_bits_in[29:23] == 7'h60;
	wire logic hit = win && mem_io_in;
	sequence s_take; $fell(address_strobe_n_in) && hit; endsequence
	chk_sel_on: assert property (hit [*4] |-> !coproc_selected_n_out) else $error("no sel");
	chk_sel_off: assert property ((!win) [*4] |-> coproc_selected_n_out) else $error("sel");
	chk_rdy_lat: assert property (s_take |-> ##[5:6] !ready_n_out) else $error("late");
	chk_rdy_early: assert property (s_take |-> ready_n_out [*4]) else $error("early");
	chk_rdy_sel: assert property (!ready_n_out |-> $past(coproc_selected_n_out, 2) == 1'b0)
		else $error("unselected");
	chk_rdy_once: assert property (!ready_n_out |=> ready_n_out) else $error("long");
	chk_exec_rdy: assert property (op_valid_out |-> !ready_n_out) else $error("exec");
	chk_present: assert property (!device_present_n_out) else $error("absent");
endmodule
bind cbi_coproc_port cbi_port_asserts i_cbi_port_asserts (.*);
`default_nettype wire

/* File: cbi_host_bus.sv */
`timescale 1ns/100ps
`default_nettype none
module cbi_host_bus (
	input  wire logic        clk_in, ready_n_out,
	input  wire logic [31:0] data_lines_out,
	output var  logic [29:0] word_address_bits_in,
	output var  logic [31:0] data_lines_in,
	output var  logic        address_strobe_n_in, mem_io_in, write_read_in,
	output wire logic        ready_n_in
);
	assign ready_n_in = ready_n_out;
	initial {word_address_bits_in, data_lines_in, address_strobe_n_in, mem_io_in, write_read_in} = 65'h4;
	task cyc(input logic w, m, logic [29:0] a, logic [31:0] d, output logic ok, logic [31:0] q);
		int n;
		@(negedge clk_in) {write_read_in, mem_io_in, word_address_bits_in, data_lines_in} = {w, m, a, d};
		address_strobe_n_in = 1'b0;
		@(negedge clk_in) address_strobe_n_in = 1'b1;
		for (n = 0; n < 12 && ready_n_in !== 1'b0; n++) @(negedge clk_in);
		{ok, q} = {n < 12, data_lines_out};
		@(negedge clk_in) {word_address_bits_in, data_lines_in} = {~a, ~d};
	endtask
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk_in = 1'b0, rst_in = 1'b1, three_cycle_bus_n_in = 1'b1, mem_io_in, write_read_in;
	logic address_strobe_n_in, ready_n_in, data_lines_oe_out, ready_n_out, coproc_selected_n_out;
	logic interrupt_request_out, device_present_n_out, op_valid_out;
	logic [31:0] data_lines_in, data_lines_out, op_data_out;
	logic [29:0] word_address_bits_in;
	logic [16:0] op_code_out;
	logic [3:0]  byte_lane_enables_n_in = 4'h0;
	int          err_total = 0, n_checks = 0;
	cbi_coproc_port i_cbi_coproc_port (.*);
	cbi_host_bus u_host (.*);
	task xfer(input logic w, m, logic [29:0] a, logic [31:0] d, logic eok, logic [31:0] eq);
		logic ok;
		logic [31:0] q;
		u_host.cyc(w, m, a, d, ok, q);
		n_checks++;
		if (ok !== eok || (!w && eok && q !== eq)) begin
			err_total++;
			$display("mismatch %0t cycle at %h", $time, a);
		end
	endtask
	task t_access;
		for (int k = 0; k < 2; k++) begin
			three_cycle_bus_n_in = k[0];
			xfer(1'b1, 1'b1, k ? 30'h307FFFFF : 30'h30000000, 32'hA5C30F1E + k, 1'b1, 32'h0);
			xfer(1'b0, 1'b1, k ? 30'h307FFFFF : 30'h30000000, 32'h0, 1'b1, 32'hA5C30F1E + k);
		end
	endtask
	task t_refuse;
		xfer(1'b1, 1'b1, 30'h30800000, 32'h1, 1'b0, 32'h0);
		xfer(1'b1, 1'b0, 30'h30000000, 32'h1, 1'b0, 32'h0);
		xfer(1'b0, 1'b1, 30'h30000000, 32'h0, 1'b1, 32'hA5C30F1E);
	endtask
	task t_irq;
		byte_lane_enables_n_in = 4'hF;
		xfer(1'b1, 1'b1, 30'h30000005, 32'h1234ABCD, 1'b1, 32'h0);
		n_checks++;
		if (interrupt_request_out !== 1'b1 || op_code_out !== 17'h0002F
			|| op_data_out !== 32'h1234ABCD) begin
			err_total++;
			$display("mismatch %0t irq or op code", $time);
		end
		byte_lane_enables_n_in = 4'h0;
		xfer(1'b0, 1'b1, 30'h30000005, 32'h0, 1'b1, 32'h1234ABCD);
		n_checks++;
		if (interrupt_request_out !== 1'b0 || data_lines_oe_out !== 1'b0
			|| device_present_n_out !== 1'b0) begin
			err_total++;
			$display("mismatch %0t irq clear, drive or presence", $time);
		end
	endtask
	task complete_run;
		if (err_total == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial forever #5 clk_in = ~clk_in;
	initial begin
		#50 rst_in = 1'b0;
		#30 t_access;
		t_refuse;
		t_irq;
		complete_run;
	end
	initial begin
		#5000 err_total++;
		complete_run;
	end
endmodule
`default_nettype wire
